// File: adcc_cfg.svh
// Register offsets, field positions, reset values and timing counts for the converter control
// Operation
// - Result is unsigned and exactly 12 bits
// - Ten inputs small variant, thirteen large variant
// - Bits 5..2 pick channel, codes 0..12
// - Codes 13..15 convert a floating input
// - Small variant: codes 5..7 are floating
// - Status bit 1 high while converting
// - Bit 0 enables the converter
// - Bits 7..6 ignore writes, read zero
// - Five registers: two result, three control
// - Control, port config, timing/format roles
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Word-aligned byte addresses on the register bus
`define ADCC_OFS_RESULT_HIGH    4'h0
`define ADCC_OFS_RESULT_LOW     4'h4
`define ADCC_OFS_CONTROL        4'h8
`define ADCC_OFS_PORT_CONFIG    4'hC
`define ADCC_ADDR_W             4

// Field positions in the control register
`define ADCC_ENABLE_BIT         0
`define ADCC_STATUS_BIT         1
`define ADCC_CHSEL_LSB          2
`define ADCC_CHSEL_MSB          5

// Reset values
`define ADCC_CONTROL_RESET      8'h00
`define ADCC_PORT_CONFIG_RESET  8'h00
`define ADCC_TIMING_RESET       8'h00
`define ADCC_TIMING_MASK        8'hBF

// Channel code limits
`define ADCC_LAST_CHANNEL       4'hC
`define ADCC_SMALL_GAP_LO       4'h5
`define ADCC_SMALL_GAP_HI       4'h7

// Timing of one conversion in ns and in cycles of the 5 ns clock
`define ADCC_CLK_PERIOD_NS      5
`define ADCC_CONV_TIME_NS       200
`define ADCC_CONV_CYCLES        ((`ADCC_CONV_TIME_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)

// Answer for an unmapped address
`define ADCC_UNMAPPED_DATA      32'h00000000

`endif

// File: adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;

    // Conversion sequencer states
    typedef enum logic [1:0]
    {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_STORE  = 2'b10
    } adcc_state_t;

    // Control register fields
    typedef struct packed
    {
        logic [3:0] channel_select;
        logic       go_busy;
        logic       converter_enable;
    } adcc_control_t;

    // Request to the analog core
    typedef struct packed
    {
        logic       start;
        logic [3:0] channel;
        logic       floating;
    } adcc_core_req_t;

endpackage

// File: adcc_chan_map.sv
// Channel code decoder: marks codes that reach no implemented input
`include "adcc_cfg.svh"

module adcc_chan_map
#(
    parameter bit SMALL_VARIANT = 1'b0      // Ten-input build when set
)
(
    input  wire logic [3:0] code_i,         // Channel code from control register
    output logic            floating_o      // Code selects no implemented input
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb
    begin
        floating_o = 1'b0;
        if (code_i > `ADCC_LAST_CHANNEL)
        begin
            floating_o = 1'b1;
        end
        else if (SMALL_VARIANT && code_i >= `ADCC_SMALL_GAP_LO
                 && code_i <= `ADCC_SMALL_GAP_HI)
        begin
            floating_o = 1'b1;
        end
    end

endmodule

// File: adcc_top.sv
// Converter control block: Avalon-MM registers, channel select and conversion sequencer
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`include "adcc_cfg.svh"

module adcc_top
#(
    parameter bit          SMALL_VARIANT = 1'b0,            // Ten-input build when set
    parameter int unsigned CONV_CYCLES   = `ADCC_CONV_CYCLES // Cycles for one conversion
)
(
    input  wire logic                    clk_i,              // 200 MHz clock
    input  wire logic                    nrst_i,             // Async reset, active low
    // Avalon-MM slave
    input  wire logic [`ADCC_ADDR_W-1:0] avs_address_i,      // Byte address
    input  wire logic                    avs_read_i,         // Read request
    input  wire logic                    avs_write_i,        // Write request
    input  wire logic [31:0]             avs_writedata_i,    // Write data
    input  wire logic [3:0]              avs_byteenable_i,   // Byte lanes
    output logic [31:0]                  avs_readdata_o,     // Read data
    output logic                         avs_waitrequest_o,  // Stall while high, answer not ready
    // Analog core side
    output adcc_pkg::adcc_core_req_t     core_req_o,         // Start pulse, channel, floating
    output logic [7:0]                   port_analog_config_o, // Port pin analog config
    output logic [7:0]                   timing_format_config_o, // Clock/acq/justify config
    input  wire logic [11:0]             core_result_i,      // Sampled level from core
    output logic                         busy_o              // Conversion in progress
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (CONV_CYCLES < 2 || CONV_CYCLES > 4096)
    begin : g_bad_cycles
        $error("CONV_CYCLES out of range");
    end

    localparam logic [12:0] CONV_LAST = 13'(CONV_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    adcc_pkg::adcc_control_t  control;          // Control register fields
    adcc_pkg::adcc_control_t  next_control;
    logic [11:0]              result;           // Stored 12-bit result
    logic [11:0]              next_result;
    logic [7:0]               port_cfg;         // Port analog config
    logic [7:0]               next_port_cfg;
    logic [7:0]               timing_cfg;       // Timing and format config
    logic [7:0]               next_timing_cfg;
    adcc_pkg::adcc_state_t    state;            // Sequencer state
    adcc_pkg::adcc_state_t    next_state;
    logic [12:0]              count;            // Conversion cycle count
    logic [12:0]              next_count;
    logic [3:0]               conv_channel;     // Channel latched at start
    logic [3:0]               next_conv_channel;
    logic                     conv_floating;    // Latched floating flag
    logic                     next_conv_floating;
    logic                     start_pulse;      // One-cycle start to core
    logic                     next_start_pulse;
    logic [31:0]              rdata;            // Registered read data
    logic [31:0]              next_rdata;
    logic                     ack;              // Answer cycle, drops waitrequest
    logic                     next_ack;
    logic                     code_floating;    // Decoder output

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Control register image, upper bits forced to zero
    function automatic logic [7:0] control_image(input adcc_pkg::adcc_control_t c);
        control_image = {2'b00, c.channel_select, c.go_busy, c.converter_enable};
    endfunction

    // Merge a byte-lane write into an 8-bit register
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        lane0 = be[0] ? wd[7:0] : old;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Channel decoder
    adcc_chan_map
    #(
        .SMALL_VARIANT (SMALL_VARIANT)
    )
    u_chan_map
    (
        .code_i     (control.channel_select),
        .floating_o (code_floating)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus, registers and sequencer next values
    logic req;
    logic wr_take;
    logic rd_take;
    logic [7:0] wbyte;

    always_comb
    begin
        next_control       = control;
        next_result        = result;
        next_port_cfg      = port_cfg;
        next_timing_cfg    = timing_cfg;
        next_state         = state;
        next_count         = count;
        next_conv_channel  = conv_channel;
        next_conv_floating = conv_floating;
        next_start_pulse   = 1'b0;
        next_rdata         = rdata;
        next_ack           = 1'b0;

        // Answer one cycle after the request; writes commit on that answer edge only
        req     = (avs_read_i || avs_write_i) && !ack;
        wr_take = ack && avs_write_i;
        rd_take = req && avs_read_i && !avs_write_i;
        wbyte   = lane0(control_image(control), avs_writedata_i, avs_byteenable_i);
        if (req)
        begin
            next_ack = 1'b1;
        end

        // Register writes; results are read-only
        if (wr_take)
        begin
            case (avs_address_i)
                `ADCC_OFS_CONTROL:
                begin
                    next_control.converter_enable = wbyte[`ADCC_ENABLE_BIT];
                    next_control.channel_select   =
                        wbyte[`ADCC_CHSEL_MSB:`ADCC_CHSEL_LSB];
                    // Software may set status but never clear it: only the sequencer ends it
                    if (wbyte[`ADCC_STATUS_BIT] && wbyte[`ADCC_ENABLE_BIT]
                        && control.converter_enable && state == adcc_pkg::ADCC_IDLE)
                    begin
                        next_control.go_busy = 1'b1;
                        next_state           = adcc_pkg::ADCC_SAMPLE;
                        next_count           = '0;
                        next_conv_channel    = wbyte[`ADCC_CHSEL_MSB:`ADCC_CHSEL_LSB];
                        next_conv_floating   = 1'b0;
                        next_start_pulse     = 1'b1;
                    end
                end
                `ADCC_OFS_PORT_CONFIG:
                begin
                    next_port_cfg = lane0(port_cfg, avs_writedata_i, avs_byteenable_i);
                end
                4'h0 + 4'h0:
                begin
                    next_port_cfg = port_cfg;
                end
                default:
                begin
                    next_port_cfg = port_cfg;
                end
            endcase
        end

        // Third control register lives in the upper lane of the port-config word
        if (wr_take && avs_address_i == `ADCC_OFS_PORT_CONFIG && avs_byteenable_i[1])
        begin
            next_timing_cfg = avs_writedata_i[15:8] & `ADCC_TIMING_MASK;
        end

        // Register reads
        if (rd_take)
        begin
            case (avs_address_i)
                `ADCC_OFS_RESULT_HIGH: next_rdata = {24'h000000, 4'h0, result[11:8]};
                `ADCC_OFS_RESULT_LOW:  next_rdata = {24'h000000, result[7:0]};
                `ADCC_OFS_CONTROL:     next_rdata = {24'h000000, control_image(control)};
                `ADCC_OFS_PORT_CONFIG: next_rdata = {16'h0000, timing_cfg, port_cfg};
                default:               next_rdata = `ADCC_UNMAPPED_DATA;
            endcase
        end

        // Conversion sequencer
        case (state)
            adcc_pkg::ADCC_IDLE:
            begin
                // Waits for a start write, which has already cleared the count
            end
            adcc_pkg::ADCC_SAMPLE:
            begin
                // Floating flag taken from decoder one cycle after start
                if (count == 13'h0000)
                begin
                    next_conv_floating = code_floating;
                end
                if (!control.converter_enable)
                begin
                    // Turning off aborts; no result is stored
                    next_state           = adcc_pkg::ADCC_IDLE;
                    next_control.go_busy = 1'b0;
                end
                else if (count == CONV_LAST)
                begin
                    next_state = adcc_pkg::ADCC_STORE;
                end
                else
                begin
                    next_count = count + 13'h0001;
                end
            end
            adcc_pkg::ADCC_STORE:
            begin
                next_result          = core_result_i;
                next_control.go_busy = 1'b0;
                next_state           = adcc_pkg::ADCC_IDLE;
            end
            default:
            begin
                next_state = adcc_pkg::ADCC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            control       <= adcc_pkg::adcc_control_t'(6'(`ADCC_CONTROL_RESET));
            result        <= 12'h000;
            port_cfg      <= `ADCC_PORT_CONFIG_RESET;
            timing_cfg    <= `ADCC_TIMING_RESET;
            state         <= adcc_pkg::ADCC_IDLE;
            count         <= 13'h0000;
            conv_channel  <= 4'h0;
            conv_floating <= 1'b0;
            start_pulse   <= 1'b0;
            rdata         <= 32'h00000000;
            ack           <= 1'b0;
        end
        else
        begin
            control       <= next_control;
            result        <= next_result;
            port_cfg      <= next_port_cfg;
            timing_cfg    <= next_timing_cfg;
            state         <= next_state;
            count         <= next_count;
            conv_channel  <= next_conv_channel;
            conv_floating <= next_conv_floating;
            start_pulse   <= next_start_pulse;
            rdata         <= next_rdata;
            ack           <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign avs_readdata_o         = rdata;
    assign avs_waitrequest_o      = !ack;
    assign core_req_o.start       = start_pulse;
    assign core_req_o.channel     = conv_channel;
    assign core_req_o.floating    = conv_floating;
    assign port_analog_config_o   = port_cfg;
    assign timing_format_config_o = timing_cfg;
    assign busy_o                 = control.go_busy;

endmodule

// File: adcc_top_properties.sv
// Concurrent checks on the converter control block ports
`include "adcc_cfg.svh"

module adcc_top_properties
#(
    parameter bit          SMALL_VARIANT = 1'b0,  // Ten-input build when set
    parameter int unsigned CONV_CYCLES   = 40     // Cycles for one conversion
)
(
    input wire logic                    clk_i,
    input wire logic                    nrst_i,
    input wire logic [`ADCC_ADDR_W-1:0] avs_address_i,
    input wire logic                    avs_read_i,
    input wire logic                    avs_write_i,
    input wire logic [31:0]             avs_writedata_i,
    input wire logic [3:0]              avs_byteenable_i,
    input wire logic [31:0]             avs_readdata_o,
    input wire logic                    avs_waitrequest_o,
    input wire adcc_pkg::adcc_core_req_t core_req_o,
    input wire logic [7:0]              port_analog_config_o,
    input wire logic [7:0]              timing_format_config_o,
    input wire logic [11:0]             core_result_i,
    input wire logic                    busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    logic [7:0] busy_cnt;       // Consecutive busy cycles
    logic [7:0] next_busy_cnt;  // Next value of the busy counter
    logic       rd_ans;         // Read answer cycle
    logic       abort_seen;     // Disable write answered, conversion may end early
    logic       next_abort_seen; // Next value of the abort flag

    assign rd_ans = avs_read_i && !avs_waitrequest_o;

    ////////////////////////////////////////////////////////////////////////////////
    // Busy length counter, cleared whenever the converter is idle
    always_comb
    begin
        next_busy_cnt   = busy_o ? busy_cnt + 8'h01 : 8'h00;
        next_abort_seen = abort_seen;
        // Cleared once idle; a disable write may legally cut a conversion short
        if (!busy_o)
            next_abort_seen = 1'b0;
        if (avs_write_i && !avs_waitrequest_o && avs_address_i == `ADCC_OFS_CONTROL
            && avs_byteenable_i[0] && !avs_writedata_i[0])
            next_abort_seen = 1'b1;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            busy_cnt   <= 8'h00;
            abort_seen <= 1'b0;
        end
        else
        begin
            busy_cnt   <= next_busy_cnt;
            abort_seen <= next_abort_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("answer late");
    answer_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
    unused_zero_a: assert property (rd_ans && avs_address_i == `ADCC_OFS_CONTROL |-> avs_readdata_o[31:6] == 26'h0) else $error("top bits set");
    result_width_a: assert property (rd_ans && avs_address_i == `ADCC_OFS_RESULT_HIGH |-> avs_readdata_o[31:4] == 28'h0) else $error("result too wide");
    unmapped_zero_a: assert property (rd_ans && avs_address_i[1:0] != 2'b00 |-> avs_readdata_o == `ADCC_UNMAPPED_DATA) else $error("unmapped data");
    start_busy_a: assert property (core_req_o.start |-> busy_o && !$past(busy_o)) else $error("start while busy");
    start_pulse_a: assert property (core_req_o.start |=> !core_req_o.start) else $error("start too long");
    chan_float_a: assert property (core_req_o.start |-> ##2 core_req_o.floating == (core_req_o.channel > `ADCC_LAST_CHANNEL
        || (SMALL_VARIANT && core_req_o.channel >= 4'h5 && core_req_o.channel <= 4'h7))) else $error("floating flag");
    chan_held_a: assert property (busy_o && $past(busy_o) |-> $stable(core_req_o.channel)) else $error("channel moved");
    busy_len_a: assert property ($fell(busy_o) && !abort_seen |-> busy_cnt == CONV_CYCLES + 1) else $error("busy length");
    timing_bit_a: assert property (timing_format_config_o[6] == 1'b0) else $error("timing bit 6");

    // Main scenarios
    conv_c: cover property (core_req_o.start ##2 !core_req_o.floating);
    float_c: cover property (core_req_o.start ##2 core_req_o.floating);
    unmap_c: cover property (rd_ans && avs_address_i[1:0] != 2'b00);
endmodule

bind adcc_top adcc_top_properties #(.SMALL_VARIANT(SMALL_VARIANT), .CONV_CYCLES(CONV_CYCLES))
    adcc_top_properties_inst (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .core_req_o(core_req_o),
    .port_analog_config_o(port_analog_config_o), .timing_format_config_o(timing_format_config_o),
    .core_result_i(core_result_i), .busy_o(busy_o));

// File: adcc_core_model.sv
// Behavioural analog core: holds the sampled level, wanders on floating inputs
module adcc_core_model
(
    input  wire logic                     clk_i,    // Device clock
    input  wire logic                     nrst_i,   // Async reset, active low
    input  wire adcc_pkg::adcc_core_req_t req_i,    // Start, channel, floating
    input  wire logic [11:0]              level_i,  // Level on the selected input
    output logic [11:0]                   result_o  // Conversion result
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [11:0] held;   // Level captured at start
    logic [11:0] noise;  // Floating input, differs every cycle

    // Capture on start; an odd step keeps the floating value moving
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            held  <= 12'h000;
            noise <= 12'hA5A;
        end
        else
        begin
            noise <= noise + 12'h3C7;
            if (req_i.start)
                held <= level_i;
        end
    end

    // Unsigned 12-bit answer; no implemented input means a floating reading
    assign result_o = req_i.floating ? noise : held;
endmodule

// File: test_adcc_top.sv
// Self-checking bench for the converter control block
`include "adcc_cfg.svh"

module test_adcc_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned CONV = 4;  // Shortened conversion keeps the run brief

    logic                     clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o;
    logic [3:0]               avs_address_i, avs_byteenable_i;
    logic [31:0]              avs_writedata_i, avs_readdata_o, rng, rd;
    adcc_pkg::adcc_core_req_t core_req_o;
    logic [7:0]               port_analog_config_o, timing_format_config_o;
    logic [11:0]              core_result_i, level;
    int                       miscompares, check_count, n, i;

    adcc_top #(.SMALL_VARIANT(1'b1), .CONV_CYCLES(CONV)) adcc_top_inst (.clk_i(clk_i),
        .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .core_req_o(core_req_o),
        .port_analog_config_o(port_analog_config_o),
        .timing_format_config_o(timing_format_config_o), .core_result_i(core_result_i),
        .busy_o(busy_o));

    adcc_core_model adcc_core_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(core_req_o),
        .level_i(level), .result_o(core_result_i));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Ten-input build: codes 5..7 and 13..15 reach nothing
    function automatic logic exp_float(input logic [3:0] c);
        return (c > 4'hC) || (c >= 4'h5 && c <= 4'h7);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One Avalon-MM transfer; the leading edge leaves one dead cycle between requests
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        avs_read_i       <= !wr;
        avs_write_i      <= wr;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (k == 20)
        begin
            miscompares++;
            give_verdict;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial
    begin
        {nrst_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hF;
        level = 12'h000;
        rng = 32'h5bf4dd38;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        check({busy_o, core_req_o, port_analog_config_o, timing_format_config_o}, 32'h0, "reset outputs");
        check(avs_waitrequest_o, 1'b1, "reset wait");
        bus(1'b0, `ADCC_OFS_CONTROL, 32'h0, 4'hF, rd);
        check(rd, 32'h0, "control reset");
        // Status set while still disabled is refused; bits 7..6 drop
        bus(1'b1, `ADCC_OFS_CONTROL, 32'hFFFF_FFFF, 4'hF, rd);
        bus(1'b0, `ADCC_OFS_CONTROL, 32'h0, 4'hF, rd);
        check(rd, 32'h0000_003D, "early start");
        check(busy_o, 1'b0, "idle");
        // Every channel code, random levels and noise in ignored bits
        for (int c = 0; c < 16; c++)
        begin
            rng = xorshift(rng);
            bus(1'b1, `ADCC_OFS_CONTROL, {rng[31:6], c[3:0], 2'b01}, 4'hF, rd);
            level <= rng[27:16];
            bus(1'b1, `ADCC_OFS_CONTROL, {rng[31:6], c[3:0], 2'b11}, 4'hF, rd);
            n = 0;
            for (i = 0; i < 100; i++)
            begin
                #1;
                if (busy_o !== 1'b1)
                    break;
                n++;
                @(posedge clk_i);
            end
            if (i == 100)
            begin
                miscompares++;
                give_verdict;
            end
            check(32'(n), 32'(CONV + 1), "busy length");
            check(core_req_o.floating, exp_float(c[3:0]), "floating");
            check(core_req_o.channel, c[3:0], "channel");
            bus(1'b0, `ADCC_OFS_CONTROL, 32'h0, 4'hF, rd);
            check(rd, {26'h0, c[3:0], 2'b01}, "control after");
            if (!exp_float(c[3:0]))
            begin
                if (c == 12)
                    bus(1'b1, `ADCC_OFS_RESULT_LOW, rng, 4'hF, rd);
                bus(1'b0, `ADCC_OFS_RESULT_HIGH, 32'h0, 4'hF, rd);
                check(rd, {28'h0, level[11:8]}, "result high");
                bus(1'b0, `ADCC_OFS_RESULT_LOW, 32'h0, 4'hF, rd);
                check(rd, {24'h0, level[7:0]}, "result low");
            end
        end
        // Port and timing configuration share one word
        rng = xorshift(rng);
        bus(1'b1, `ADCC_OFS_PORT_CONFIG, rng, 4'h3, rd);
        bus(1'b0, `ADCC_OFS_PORT_CONFIG, 32'h0, 4'hF, rd);
        check(rd, {16'h0, rng[15:8] & `ADCC_TIMING_MASK, rng[7:0]}, "config");
        check({port_analog_config_o, timing_format_config_o}, {rng[7:0], rng[15:8] & 8'hBF}, "cfg pins");
        bus(1'b0, 4'h2, 32'h0, 4'hF, rd);
        check(rd, `ADCC_UNMAPPED_DATA, "unmapped");
        // Disabling mid-conversion aborts it and stores nothing
        bus(1'b0, `ADCC_OFS_RESULT_LOW, 32'h0, 4'hF, rd);
        n = int'(rd);
        bus(1'b1, `ADCC_OFS_CONTROL, 32'h0000_0003, 4'hF, rd);
        bus(1'b1, `ADCC_OFS_CONTROL, 32'h0, 4'hF, rd);
        @(posedge clk_i);
        #1;
        check(busy_o, 1'b0, "disabled");
        bus(1'b0, `ADCC_OFS_CONTROL, 32'h0, 4'hF, rd);
        check(rd, 32'h0, "off");
        bus(1'b0, `ADCC_OFS_RESULT_LOW, 32'h0, 4'hF, rd);
        check(rd, 32'(n), "abort kept result");
        give_verdict;
    end
endmodule
